/* File: hw/ppm_port_pin_function_mux.sv */
// Pin-function multiplexer for four 8-bit ports, the latch pulse pin and
// the fixed-function debug and strobe pins.
// Assumes the core, timers, serial ports and counter arrays run on mclk;
// pin inputs are asynchronous and pass four flip-flops here, three stages and the agreed output.
// Notes on behaviour
// - With suppression set, latch pulse only during external data accesses.
// - Port 0 forced push-pull while carrying bus or second array outputs.
// - Port 0 carries low address and bidirectional data during external cycles.
// - Port 2 outputs high address, push-pull then and with first array.
// - Port 1 bits 4 and 6 are rising-edge interrupts 2 and 4.
// - Port 1 bits 5 and 7 are falling-edge interrupts 3 and 5.
// - Port 1 bit 0 counts timer 2, bit 1 triggers its capture.
// - Port 3 bit 0 receives, bit 1 transmits, first serial port.
// - Port 3 bits 2 and 3 are active-low interrupts 0 and 1.
// - Port 3 bits 4 and 5 count timers 0 and 1.
// - Port 3 bit 6 write strobe, bit 7 read strobe, external cycles.
// - Any port bit selectable as converter channel 8n plus b.
// - Port 0 bits 6 and 7 clock the second and first arrays.
// - Debug pins keep pull-up on and act quasi-bidirectional.
// - Program strobe pin is a pulled-up special input, never fetches code.
// - External code access pin is ignored entirely.
`timescale 1ns/1ps
module ppm_port_pin_function_mux
    import ppm_pkg::*;
#(
    parameter int W = PORT_W
)
(
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    // Port pins and core-side port configuration
    input  wire logic [NUM_PORTS*W-1:0] port_pin_in,
    input  wire logic [NUM_PORTS*W-1:0] port_latch,
    input  wire logic [NUM_PORTS*W-1:0] port_push_pull,
    input  wire logic [NUM_PORTS*W-1:0] port_output_dir,
    output logic [NUM_PORTS*W-1:0]      port_pin_out,
    output logic [NUM_PORTS*W-1:0]      port_pin_oe,
    output logic [NUM_PORTS*W-1:0]      port_pin_in_sync,
    // External data memory cycle from the core
    input  wire logic                 xmem_active,
    input  wire logic                 xmem_addr_phase,
    input  wire logic                 xmem_write,
    input  wire logic                 xmem_rd_strobe,
    input  wire logic                 xmem_wr_strobe,
    input  wire logic [W-1:0]         xmem_addr_lo,
    input  wire logic [W-1:0]         xmem_addr_hi,
    input  wire logic [W-1:0]         xmem_wdata,
    output logic [W-1:0]              xmem_rdata,
    // Address latch pulse
    input  wire logic                 latch_pulse_suppress,
    input  wire logic                 latch_pulse_core,
    output logic                      latch_pulse_pin_out,
    output logic                      latch_pulse_pin_oe,
    // Counter arrays
    input  wire logic                 counter_array0_en,
    input  wire logic                 counter_array1_en,
    input  wire logic [CA_OUT_W-1:0]  counter_array0_outputs,
    input  wire logic [CA_OUT_W-1:0]  counter_array1_outputs,
    output logic                      counter_array0_ext_clock,
    output logic                      counter_array1_ext_clock,
    // Timers and interrupts
    output logic                      timer0_count_input,
    output logic                      timer1_count_input,
    output logic                      timer2_count_input,
    output logic                      timer2_trigger_input,
    output logic                      ext_irq0_low,
    output logic                      ext_irq1_low,
    output logic                      ext_irq2_rising,
    output logic                      ext_irq3_falling,
    output logic                      ext_irq4_rising,
    output logic                      ext_irq5_falling,
    // Serial ports
    input  wire logic                 serial0_tx_en,
    input  wire logic                 serial0_tx_data,
    output logic                      serial0_receive,
    input  wire logic                 serial1_en,
    input  wire logic                 serial1_transmit_data,
    output logic                      serial1_receive,
    // Analog converter channel selection
    input  wire logic [NUM_PORTS*W-1:0] adc_channel_enable,
    output logic [NUM_PORTS*W-1:0]      adc_pin_connect,
    // Fixed-function pins
    input  wire logic                 debug_data_pin_in,
    input  wire logic                 debug_data_drive_low,
    output logic                      debug_data_pin_out,
    output logic                      debug_data_pin_oe,
    output logic                      debug_data_pullup,
    output logic                      debug_data_sync,
    input  wire logic                 debug_clock_pin_in,
    input  wire logic                 debug_clock_drive_low,
    output logic                      debug_clock_pin_out,
    output logic                      debug_clock_pin_oe,
    output logic                      debug_clock_pullup,
    output logic                      debug_clock_sync,
    input  wire logic                 program_strobe_pin_in,
    output logic                      program_strobe_pullup,
    output logic                      program_strobe_sync,
    input  wire logic                 external_code_access_pin
);
    localparam int NB = NUM_PORTS * W;

    logic [NB-1:0] sync_in;
    logic          dbg_d_s;
    logic          dbg_c_s;
    logic          pstb_s;
    logic          irq2_p;
    logic          irq3_p;
    logic          irq4_p;
    logic          irq5_p;

    logic [NB-1:0] out_ff, nxt_out;
    logic [NB-1:0] oe_ff, nxt_oe;
    logic [NB-1:0] adc_ff, nxt_adc;
    logic [W-1:0]  rdata_ff, nxt_rdata;
    logic          ale_ff, nxt_ale;
    logic          ddo_ff, nxt_ddo;
    logic          dco_ff, nxt_dco;
    logic [11:0]   alt_ff, nxt_alt;

    // Every pin input is synchronised; all consumers see the same copy
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_sync
            ppm_sync u_s (.mclk(mclk), .nrst(nrst), .din(port_pin_in[g]), .dout(sync_in[g]));
        end
    endgenerate

    ppm_sync u_sdd (.mclk(mclk), .nrst(nrst), .din(debug_data_pin_in), .dout(dbg_d_s));
    ppm_sync u_sdc (.mclk(mclk), .nrst(nrst), .din(debug_clock_pin_in), .dout(dbg_c_s));
    ppm_sync u_sps (.mclk(mclk), .nrst(nrst), .din(program_strobe_pin_in), .dout(pstb_s));

    // Edge-triggered interrupts on port 1
    ppm_edge #(.RISING(1'b1)) u_e2 (.mclk(mclk), .nrst(nrst),
        .din(sync_in[W+P1_IRQ2_BIT]), .pulse(irq2_p));
    ppm_edge #(.RISING(1'b0)) u_e3 (.mclk(mclk), .nrst(nrst),
        .din(sync_in[W+P1_IRQ3_BIT]), .pulse(irq3_p));
    ppm_edge #(.RISING(1'b1)) u_e4 (.mclk(mclk), .nrst(nrst),
        .din(sync_in[W+P1_IRQ4_BIT]), .pulse(irq4_p));
    ppm_edge #(.RISING(1'b0)) u_e5 (.mclk(mclk), .nrst(nrst),
        .din(sync_in[W+P1_IRQ5_BIT]), .pulse(irq5_p));

    // Output mux: alternate functions win over the latch when active
    always_comb begin
        logic [W-1:0] p0o, p0e, p1o, p1e, p2o, p2e, p3o, p3e;
        logic [W-1:0] pp0, pp2;
        p0o = port_latch[0*W +: W];
        p1o = port_latch[1*W +: W];
        p2o = port_latch[2*W +: W];
        p3o = port_latch[3*W +: W];
        // Open-drain drives only lows unless push-pull is set or forced
        pp0 = port_push_pull[0*W +: W];
        pp2 = port_push_pull[2*W +: W];
        if (counter_array1_en) begin
            p0o[CA_OUT_W-1:0] = counter_array1_outputs;
            pp0 = {W{1'b1}};
        end
        if (counter_array0_en) begin
            p2o[CA_OUT_W-1:0] = counter_array0_outputs;
            pp2 = {W{1'b1}};
        end
        if (serial1_en) begin
            p2o[P2_TX1_BIT] = serial1_transmit_data;
            p2o[P2_RX1_BIT] = 1'b1;
        end
        if (serial0_tx_en) begin
            p3o[P3_TX0_BIT] = serial0_tx_data;
        end
        p0e = port_output_dir[0*W +: W] & (pp0 | ~p0o);
        p1e = port_output_dir[1*W +: W] & (port_push_pull[1*W +: W] | ~p1o);
        p2e = port_output_dir[2*W +: W] & (pp2 | ~p2o);
        p3e = port_output_dir[3*W +: W] & (port_push_pull[3*W +: W] | ~p3o);
        if (xmem_active) begin
            // Address phase, then write data or release for read data
            p0o = xmem_addr_phase ? xmem_addr_lo : xmem_wdata;
            p0e = (xmem_addr_phase | xmem_write) ? {W{1'b1}} : ZERO_BYTE;
            p2o = xmem_addr_hi;
            p2e = {W{1'b1}};
            p3o[P3_WR_BIT] = xmem_wr_strobe;
            p3o[P3_RD_BIT] = xmem_rd_strobe;
            p3e[P3_WR_BIT] = 1'b1;
            p3e[P3_RD_BIT] = 1'b1;
        end
        // A pin given to the converter is not driven
        p0e = p0e & ~adc_channel_enable[0*W +: W];
        p1e = p1e & ~adc_channel_enable[1*W +: W];
        p2e = p2e & ~adc_channel_enable[2*W +: W];
        p3e = p3e & ~adc_channel_enable[3*W +: W];
        nxt_out   = {p3o, p2o, p1o, p0o};
        nxt_oe    = {p3e, p2e, p1e, p0e};
        nxt_adc   = adc_channel_enable;
        nxt_rdata = sync_in[0*W +: W];
        // Suppressed latch pulses only inside external data cycles
        nxt_ale   = latch_pulse_core & (~latch_pulse_suppress | xmem_active);
        // Quasi-bidirectional: drive low only, pull-up holds high
        nxt_ddo   = debug_data_drive_low;
        nxt_dco   = debug_clock_drive_low;
        nxt_alt   = {sync_in[3*W+P3_RX0_BIT], sync_in[2*W+P2_RX1_BIT],
                     sync_in[W+P1_T2_BIT], sync_in[W+P1_TIMER2_TRIGGER_INPUT_BIT],
                     sync_in[3*W+P3_T0_BIT], sync_in[3*W+P3_T1_BIT],
                     sync_in[3*W+P3_IRQ0_BIT], sync_in[3*W+P3_IRQ1_BIT],
                     sync_in[P0_COUNTER_ARRAY0_EXT_CLOCK_BIT], sync_in[P0_COUNTER_ARRAY1_EXT_CLOCK_BIT],
                     dbg_d_s, dbg_c_s};
    end

    // Register every pin-facing and consumer-facing value
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_ff   <= {NUM_PORTS{PORT_RST}};
            oe_ff    <= '0;
            adc_ff   <= '0;
            rdata_ff <= ZERO_BYTE;
            ale_ff   <= 1'b0;
            ddo_ff   <= 1'b0;
            dco_ff   <= 1'b0;
            alt_ff   <= '1;
        end else begin
            out_ff   <= nxt_out;
            oe_ff    <= nxt_oe;
            adc_ff   <= nxt_adc;
            rdata_ff <= nxt_rdata;
            ale_ff   <= nxt_ale;
            ddo_ff   <= nxt_ddo;
            dco_ff   <= nxt_dco;
            alt_ff   <= nxt_alt;
        end
    end

    // Port inputs stay readable whatever function is selected
    assign port_pin_in_sync         = sync_in;
    assign port_pin_out             = out_ff;
    assign port_pin_oe              = oe_ff;
    assign adc_pin_connect          = adc_ff;
    assign xmem_rdata               = rdata_ff;
    assign latch_pulse_pin_out      = ale_ff;
    assign latch_pulse_pin_oe       = 1'b1;
    assign serial0_receive          = alt_ff[11];
    assign serial1_receive          = alt_ff[10];
    assign timer2_count_input       = alt_ff[9];
    assign timer2_trigger_input     = alt_ff[8];
    assign timer0_count_input       = alt_ff[7];
    assign timer1_count_input       = alt_ff[6];
    assign ext_irq0_low             = alt_ff[5];
    assign ext_irq1_low             = alt_ff[4];
    assign counter_array0_ext_clock = alt_ff[3];
    assign counter_array1_ext_clock = alt_ff[2];
    assign debug_data_sync          = alt_ff[1];
    assign debug_clock_sync         = alt_ff[0];
    assign ext_irq2_rising          = irq2_p;
    assign ext_irq3_falling         = irq3_p;
    assign ext_irq4_rising          = irq4_p;
    assign ext_irq5_falling         = irq5_p;
    assign debug_data_pin_out       = 1'b0;
    assign debug_data_pin_oe        = ddo_ff;
    assign debug_data_pullup        = 1'b1;
    assign debug_clock_pin_out      = 1'b0;
    assign debug_clock_pin_oe       = dco_ff;
    assign debug_clock_pullup       = 1'b1;
    // Strobe pin is input only; its level never reaches instruction fetch
    assign program_strobe_pullup    = 1'b1;
    assign program_strobe_sync      = pstb_s;
    // The code access pin has no load at all inside the block
endmodule

/* File: hw/ppm_pkg.sv */
// Constants for the port pin-function multiplexer.
// Assumes one system clock and an active-low asynchronous reset.
package ppm_pkg;
    localparam int PORT_W       = 8;
    localparam int NUM_PORTS    = 4;
    localparam int ADC_CH       = 32;
    localparam int ADC_CH_W     = 5;
    // Port 0 bit positions
    localparam int P0_COUNTER_ARRAY1_EXT_CLOCK_BIT  = 6;
    localparam int P0_COUNTER_ARRAY0_EXT_CLOCK_BIT  = 7;
    localparam int CA_OUT_W     = 6;
    // Port 1 bit positions
    localparam int P1_T2_BIT    = 0;
    localparam int P1_TIMER2_TRIGGER_INPUT_BIT  = 1;
    localparam int P1_IRQ2_BIT  = 4;
    localparam int P1_IRQ3_BIT  = 5;
    localparam int P1_IRQ4_BIT  = 6;
    localparam int P1_IRQ5_BIT  = 7;
    // Port 2 bit positions of the second serial port
    localparam int P2_RX1_BIT   = 6;
    localparam int P2_TX1_BIT   = 7;
    // Port 3 bit positions
    localparam int P3_RX0_BIT   = 0;
    localparam int P3_TX0_BIT   = 1;
    localparam int P3_IRQ0_BIT  = 2;
    localparam int P3_IRQ1_BIT  = 3;
    localparam int P3_T0_BIT    = 4;
    localparam int P3_T1_BIT    = 5;
    localparam int P3_WR_BIT    = 6;
    localparam int P3_RD_BIT    = 7;
    // Reset values
    localparam logic [7:0] PORT_RST  = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [2:0] SYNC_RST  = 3'b111;
endpackage

/* File: hw/ppm_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin input; output changes once stages two and three agree.
`timescale 1ns/1ps
module ppm_sync
    import ppm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_ff;
    logic [2:0] nxt_sh;
    logic       q_ff;
    logic       nxt_q;

    // Shift and accept only agreed levels; first stage feeds only the second
    always_comb begin
        nxt_sh = {sh_ff[1:0], din};
        nxt_q  = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : q_ff;
    end

    // Pins idle high after reset like pulled-up port lines
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sh_ff <= SYNC_RST;
            q_ff  <= 1'b1;
        end else begin
            sh_ff <= nxt_sh;
            q_ff  <= nxt_q;
        end
    end

    assign dout = q_ff;
endmodule

/* File: hw/ppm_edge.sv */
// Edge detector on a synchronised level.
// Assumes input already in the mclk domain; pulse lasts one cycle.
`timescale 1ns/1ps
module ppm_edge
    import ppm_pkg::*;
#(
    parameter bit RISING = 1'b1
)
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      pulse
);
    logic prev_ff;
    logic pulse_ff;
    logic nxt_pulse;

    // Pick the edge direction at elaboration
    always_comb begin
        nxt_pulse = RISING ? (din & ~prev_ff) : (~din & prev_ff);
    end

    // Previous level resets high so no false rising edge at release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_ff  <= 1'b1;
            pulse_ff <= 1'b0;
        end else begin
            prev_ff  <= din;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;
endmodule

/* File: sim/ppm_board_model.sv */
// Board model: external data memory on port 0, bench levels on
// every pin the multiplexer releases.
// Assumes the read strobe sits on port 3 bit 7 and is active low.
`timescale 1ns/1ps
module ppm_board_model
    import ppm_pkg::*;
(
    input  wire logic [NUM_PORTS*PORT_W-1:0] pin_out,
    input  wire logic [NUM_PORTS*PORT_W-1:0] pin_oe,
    input  wire logic [NUM_PORTS*PORT_W-1:0] board_level,
    input  wire logic [PORT_W-1:0]           mem_data,
    output logic      [NUM_PORTS*PORT_W-1:0] pin_level
);
    localparam int RD = 3*PORT_W+P3_RD_BIT;
    // A driven pin wins; memory answers only once port 0 is released
    always_comb begin
        pin_level = (pin_out & pin_oe) | (board_level & ~pin_oe);
        if (pin_oe[RD] && !pin_out[RD] && pin_oe[PORT_W-1:0] == ZERO_BYTE) begin
            pin_level[PORT_W-1:0] = mem_data;
        end
    end
endmodule

/* File: sim/ppm_mux_checker.sv */
// Concurrent checks on the multiplexer's top-level ports.
// Assumes binding into the multiplexer; one clock, async low reset.
`timescale 1ns/1ps
module ppm_mux_checker
    import ppm_pkg::*;
#(
    parameter int W = PORT_W
)
(
    input wire logic                   mclk,
    input wire logic                   nrst,
    input wire logic [NUM_PORTS*W-1:0] port_pin_out,
    input wire logic [NUM_PORTS*W-1:0] port_pin_oe,
    input wire logic [NUM_PORTS*W-1:0] port_pin_in_sync,
    input wire logic [NUM_PORTS*W-1:0] adc_channel_enable,
    input wire logic [NUM_PORTS*W-1:0] adc_pin_connect,
    input wire logic                   xmem_active,
    input wire logic                   xmem_addr_phase,
    input wire logic                   xmem_write,
    input wire logic                   xmem_rd_strobe,
    input wire logic                   xmem_wr_strobe,
    input wire logic [W-1:0]           xmem_addr_lo,
    input wire logic [W-1:0]           xmem_addr_hi,
    input wire logic [W-1:0]           xmem_wdata,
    input wire logic                   latch_pulse_suppress,
    input wire logic                   latch_pulse_pin_out,
    input wire logic                   ext_irq2_rising,
    input wire logic                   ext_irq3_falling,
    input wire logic                   debug_data_drive_low,
    input wire logic                   debug_data_pin_oe,
    input wire logic                   debug_data_pullup,
    input wire logic                   debug_clock_pullup,
    input wire logic                   program_strobe_pullup
);
    localparam int WR = 3*W+P3_WR_BIT;
    localparam int RD = 3*W+P3_RD_BIT;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Steps of one external data cycle
    sequence addr_s; xmem_active && xmem_addr_phase; endsequence
    sequence rd_s; xmem_active && !xmem_addr_phase && !xmem_write; endsequence
    sequence wr_s; xmem_active && !xmem_addr_phase && xmem_write; endsequence
    latch_gate_a: assert property (
        latch_pulse_suppress && !xmem_active |=> !latch_pulse_pin_out)
        else $error("stray latch pulse");
    low_addr_a: assert property (
        addr_s |=> port_pin_out[W-1:0] == $past(xmem_addr_lo) && &port_pin_oe[W-1:0])
        else $error("no low address");
    high_addr_a: assert property (
        addr_s |=> port_pin_out[3*W-1:2*W] == $past(xmem_addr_hi) && &port_pin_oe[3*W-1:2*W])
        else $error("no high address");
    bus_release_a: assert property (
        rd_s |=> port_pin_oe[W-1:0] == ZERO_BYTE)
        else $error("port 0 driven during read");
    write_data_a: assert property (
        wr_s |=> port_pin_out[W-1:0] == $past(xmem_wdata) && &port_pin_oe[W-1:0])
        else $error("no write data");
    strobe_pins_a: assert property (
        xmem_active |=> {port_pin_out[RD], port_pin_out[WR], port_pin_oe[RD], port_pin_oe[WR]}
            == {$past(xmem_rd_strobe), $past(xmem_wr_strobe), 2'b11})
        else $error("strobe pins wrong");
    adc_isolate_a: assert property (
        1'b1 |=> (port_pin_oe & $past(adc_channel_enable)) == '0
            && adc_pin_connect == $past(adc_channel_enable))
        else $error("converter pin driven");
    irq_single_a: assert property (
        ext_irq2_rising |=> !ext_irq2_rising)
        else $error("rising pulse too long");
    irq_fall_a: assert property (
        ext_irq3_falling |-> !port_pin_in_sync[W+P1_IRQ3_BIT]
            || !$past(port_pin_in_sync[W+P1_IRQ3_BIT]))
        else $error("falling pulse without low");
    debug_pins_a: assert property (
        debug_data_drive_low |=> debug_data_pin_oe
            && debug_data_pullup && debug_clock_pullup && program_strobe_pullup)
        else $error("debug pin wrong");
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the pin multiplexer and board model.
// Assumes the package compiles first; drives at falling edges.
`timescale 1ns/1ps
module testbench;
    import ppm_pkg::*;
    localparam int W = PORT_W;
    logic [31:0] port_pin_in, port_latch, port_push_pull, port_output_dir, port_pin_out;
    logic [31:0] port_pin_oe, port_pin_in_sync, adc_channel_enable, adc_pin_connect;
    logic [31:0] board_level, rnd;
    logic [7:0]  xmem_addr_lo, xmem_addr_hi, xmem_wdata, xmem_rdata, mem_data;
    logic [5:0]  counter_array0_outputs, counter_array1_outputs;
    logic mclk, nrst, xmem_active, xmem_addr_phase, xmem_write, xmem_rd_strobe, xmem_wr_strobe;
    logic latch_pulse_suppress, latch_pulse_core, latch_pulse_pin_out, latch_pulse_pin_oe;
    logic counter_array0_en, counter_array1_en, counter_array0_ext_clock, counter_array1_ext_clock;
    logic timer0_count_input, timer1_count_input, timer2_count_input, timer2_trigger_input;
    logic ext_irq0_low, ext_irq1_low, ext_irq2_rising, ext_irq3_falling, ext_irq4_rising;
    logic ext_irq5_falling, serial0_tx_en, serial0_tx_data, serial0_receive, serial1_en;
    logic serial1_transmit_data, serial1_receive, debug_data_pin_in, debug_data_drive_low;
    logic debug_data_pin_out, debug_data_pin_oe, debug_data_pullup, debug_data_sync;
    logic debug_clock_pin_in, debug_clock_drive_low, debug_clock_pin_out, debug_clock_pin_oe;
    logic debug_clock_pullup, debug_clock_sync, program_strobe_pin_in, program_strobe_pullup;
    logic program_strobe_sync, external_code_access_pin, dbg_hold_low;
    int   bad_count = 0;
    int   total_checks = 0;
    logic [15:0] cnt;
    ppm_port_pin_function_mux dut_u (.*);
    ppm_board_model brd_u (.pin_out(port_pin_out), .pin_oe(port_pin_oe),
        .board_level(board_level), .mem_data(mem_data), .pin_level(port_pin_in));
    // Pulled-up debug lines; the board may also hold them low
    assign debug_data_pin_in = !(debug_data_pin_oe || dbg_hold_low);
    assign debug_clock_pin_in = !(debug_clock_pin_oe || dbg_hold_low);
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Open-drain bits drive only a zero
    function automatic logic [31:0] exp_oe(logic [31:0] l, logic [31:0] p, logic [31:0] d);
        return d & (p | ~l);
    endfunction
    function automatic logic [9:0] exp_alt(logic [31:0] b);
        return {b[P0_COUNTER_ARRAY0_EXT_CLOCK_BIT], b[P0_COUNTER_ARRAY1_EXT_CLOCK_BIT], b[W+P1_T2_BIT], b[W+P1_TIMER2_TRIGGER_INPUT_BIT],
                b[2*W+P2_RX1_BIT], b[3*W+P3_RX0_BIT], b[3*W+P3_IRQ0_BIT],
                b[3*W+P3_IRQ1_BIT], b[3*W+P3_T0_BIT], b[3*W+P3_T1_BIT]};
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Nibble counts of pulses per interrupt after moving port 1 bits 4 to 7
    task automatic edge_count(logic lvl, logic [15:0] exp);
        cnt = '0;
        board_level[15:12] = {4{lvl}};
        for (int i = 0; i < 12; i++) begin
            cyc(1);
            cnt += {3'b000, ext_irq5_falling, 3'b000, ext_irq4_rising,
                    3'b000, ext_irq3_falling, 3'b000, ext_irq2_rising};
        end
        check(cnt, exp);
    endtask
    // Cuts a hang short
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
    initial begin
        rnd = 32'h0000_0016;
        {xmem_active, xmem_addr_phase, xmem_write, latch_pulse_suppress, latch_pulse_core} = '0;
        {counter_array0_en, counter_array1_en, serial0_tx_en, serial0_tx_data, serial1_en} = '0;
        {serial1_transmit_data, debug_data_drive_low, debug_clock_drive_low, dbg_hold_low} = '0;
        {external_code_access_pin, xmem_rd_strobe, xmem_wr_strobe, program_strobe_pin_in} = '1;
        {xmem_addr_lo, xmem_addr_hi, xmem_wdata, mem_data} = '0;
        {counter_array0_outputs, counter_array1_outputs} = '0;
        {port_latch, port_push_pull, port_output_dir, adc_channel_enable} = '0;
        board_level = '1;
        nrst = 1'b0;
        cyc(2);
        check(port_pin_out, {4{PORT_RST}});
        check(port_pin_oe, 32'h0000_0000);
        nrst = 1'b1;
        // Random drive; the code access pin changes nothing
        port_output_dir = '1;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            port_latch = rnd;
            port_push_pull = lfsr(rnd);
            external_code_access_pin = rnd[3];
            cyc(1);
            check(port_pin_out, port_latch);
            check(port_pin_oe, exp_oe(port_latch, port_push_pull, port_output_dir));
        end
        // Array and serial outputs beat open-drain latches
        port_latch = '1;
        port_push_pull = '0;
        {counter_array0_en, counter_array1_en, serial0_tx_en, serial1_en} = '1;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            {serial0_tx_data, serial1_transmit_data} = rnd[13:12];
            {counter_array1_outputs, counter_array0_outputs} = rnd[11:0];
            cyc(1);
            check(port_pin_out[7:0], {2'b11, counter_array1_outputs});
            check(port_pin_out[21:16], counter_array0_outputs);
            check({port_pin_oe[7:0], port_pin_oe[21:16]}, 14'h3fff);
            check({port_pin_out[25], port_pin_out[23:22]}, {rnd[13:12], 1'b1});
        end
        {counter_array0_en, counter_array1_en, serial0_tx_en, serial1_en} = '0;
        // External data cycles, latch pulse suppressed
        port_output_dir = '0;
        latch_pulse_core = 1'b1;
        cyc(1);
        check(latch_pulse_pin_out, 1'b1);
        latch_pulse_suppress = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            {xmem_addr_lo, xmem_addr_hi, xmem_wdata, mem_data} = rnd;
            {xmem_active, xmem_addr_phase, xmem_write} = {2'b11, rnd[i]};
            cyc(1);
            check(latch_pulse_pin_out, 1'b1);
            check({port_pin_oe[7:0], port_pin_out[7:0]}, {8'hff, xmem_addr_lo});
            check({port_pin_oe[23:16], port_pin_out[23:16]}, {8'hff, xmem_addr_hi});
            xmem_addr_phase = 1'b0;
            {xmem_rd_strobe, xmem_wr_strobe} = {xmem_write, !xmem_write};
            cyc(1);
            check(port_pin_out[31:30], {xmem_rd_strobe, xmem_wr_strobe});
            if (xmem_write) check(port_pin_out[7:0], xmem_wdata);
            else check(port_pin_oe[7:0], 8'h00);
            cyc(6 + 2 * i);
            if (!xmem_write) check(xmem_rdata, mem_data);
            {xmem_active, xmem_rd_strobe, xmem_wr_strobe} = 3'b011;
            cyc(1);
            check(latch_pulse_pin_out, 1'b0);
        end
        // Released pins read back
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            board_level = rnd;
            {dbg_hold_low, program_strobe_pin_in} = rnd[1:0];
            cyc(8);
            check(port_pin_in_sync, board_level);
            check({counter_array0_ext_clock, counter_array1_ext_clock, timer2_count_input,
                   timer2_trigger_input, serial1_receive, serial0_receive, ext_irq0_low,
                   ext_irq1_low, timer0_count_input, timer1_count_input},
                  exp_alt(board_level));
            check({debug_data_sync, debug_clock_sync, program_strobe_sync},
                  {!rnd[1], !rnd[1], rnd[0]});
        end
        // Rising edges fire 2 and 4, falling 3 and 5
        board_level[15:12] = 4'h0;
        cyc(8);
        edge_count(1'b1, 16'h0101);
        edge_count(1'b0, 16'h1010);
        // Converter pins undriven; debug pins only pull low
        {port_output_dir, port_push_pull} = '1;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            adc_channel_enable = rnd;
            {debug_data_drive_low, debug_clock_drive_low} = rnd[5:4];
            cyc(1);
            check(port_pin_oe, ~adc_channel_enable);
            check(adc_pin_connect, adc_channel_enable);
            check({debug_data_pin_oe, debug_clock_pin_oe, debug_data_pin_out, debug_clock_pin_out,
                   debug_data_pullup, debug_clock_pullup, program_strobe_pullup},
                  {rnd[5:4], 5'b00111});
        end
        print_verdict();
    end
endmodule
bind ppm_port_pin_function_mux ppm_mux_checker #(.W(W)) chk_u (.*);
